// ### include/uhf_pkg.sv
package uhf_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    // Host spacing between FIFO strobes: two CPU clocks plus a margin
    localparam int ACCESS_GAP_CPU_CLKS = 2;
    localparam int ACCESS_GAP_EXTRA_NS = 15;
    localparam int ACCESS_GAP_CYC = ACCESS_GAP_CPU_CLKS
        + (ACCESS_GAP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Register offsets on the three address lines
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_IIR_FCR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_SCR = 3'h7;
    localparam logic [2:0] OFS_EVT_STS = 3'h4;
    localparam logic [2:0] OFS_EVT_MSK = 3'h5;
    // Divisor-latch access qualifier for decoding
    localparam logic [1:0] DL_OFF = 2'h0;
    localparam logic [1:0] DL_ON = 2'h1;
    localparam logic [1:0] DL_ANY = 2'h2;
    // Field positions
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RXRST_BIT = 1;
    localparam int FCR_TXRST_BIT = 2;
    localparam int FCR_DMA_BIT = 3;
    localparam int FCR_TRIG_LSB = 6;
    localparam int IER_RX_BIT = 0;
    localparam int IER_TX_BIT = 1;
    localparam int LCR_STB_BIT = 2;
    localparam int LCR_PEN_BIT = 3;
    localparam int LCR_DLAB_BIT = 7;
    localparam int EVT_TRIG_BIT = 0;
    localparam int EVT_TMO_BIT = 1;
    localparam int EVT_OVR_BIT = 2;
    localparam int EVT_W = 3;
    // Interrupt identification codes
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_THRE = 4'h2;
    localparam logic [3:0] IIR_RXDATA = 4'h4;
    localparam logic [3:0] IIR_TIMEOUT = 4'hc;
    localparam logic [CNT_W-1:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    // Character framing
    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] BASE_WORD_BITS = 4'h5;
    localparam logic [3:0] ONE_STOP = 4'h1;
    localparam logic [3:0] TWO_STOP = 4'h2;
    localparam int TIMEOUT_CHARS = 4;
    // Reset values
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] TRIG_RST = 2'h0;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_RD = 2'b01,
        ACC_WR = 2'b10
    } uhf_acc_t;
endpackage

// ### include/uhf_fifo_if.sv
`timescale 1ns/10ps
interface uhf_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 16);
    localparam int CW = $clog2(DEPTH + 1);
    logic clear;
    logic one_deep;
    logic push;
    logic [WIDTH-1:0] push_data;
    logic pop;
    logic [WIDTH-1:0] head;
    logic [CW-1:0] count;
    logic full;
    logic empty;
    modport user (output clear, one_deep, push, push_data, pop,
        input head, count, full, empty);
    modport store (input clear, one_deep, push, push_data, pop,
        output head, count, full, empty);
endinterface

// ### logic/uhf_fifo.sv
`timescale 1ns/10ps
// Depth must be a power of two so that the pointers wrap by themselves
module uhf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    uhf_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic do_push, do_pop;

    // Single-buffer mode keeps one entry only
    assign f.full = f.one_deep ? (cnt_ff != '0) : (cnt_ff == CW'(DEPTH));
    assign f.empty = (cnt_ff == '0);
    assign do_push = f.push && !f.full;
    assign do_pop = f.pop && !f.empty;
    assign nxt_wp = f.clear ? '0 : wp_ff + AW'(do_push);
    assign nxt_rp = f.clear ? '0 : rp_ff + AW'(do_pop);
    assign nxt_cnt = f.clear ? '0 : cnt_ff + CW'(do_push) - CW'(do_pop);
    assign f.count = cnt_ff;
    assign f.head = mem_ff[rp_ff];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wp_ff] <= f.push_data;
        end
    end
endmodule // uhf_fifo

// ### logic/uhf_host_port.sv
// Summary of operation
// - FIFO enable bit turns on both FIFOs
// - Receive and transmit FIFOs hold sixteen bytes
// - DMA mode only effective with FIFOs enabled
// - FIFOs off means single character buffers
// - Host reads receive buffer, FIFO order
// - Host writes transmit buffer, queued in order
// - Data ready flag while receive FIFO nonempty
// - Code 4h while count at trigger level
// - Interrupt pin follows receive trigger level
// - Code Ch after four idle character times
// - Second stop bit counts in character time
// - Interrupt pin active high, drops when cleared
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module uhf_host_port #(
    parameter int DEPTH = uhf_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic device_select_n,
    input wire logic rd_strobe_n,
    input wire logic write_pulse_n,
    input wire logic addr_bit_zero,
    input wire logic addr_bit_one,
    input wire logic addr_bit_two,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic host_interrupt_out,
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    input wire logic bit_tick,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    input wire logic tx_out_ready,
    output logic dma_mode_active,
    output logic [7:0] line_ctrl,
    output logic [15:0] baud_divisor
);
    import uhf_pkg::*;

    localparam int NPIN = 14;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs,
                                 input logic dl, input logic [1:0] dmode);
        return (a == ofs) && (dmode[1] || (dmode[0] == dl));
    endfunction

    // Host pins: three flops, a change counts once stages two and three agree
    logic [NPIN-1:0] pin_raw, s1_ff, s2_ff, s3_ff, filt_ff, agree;
    assign pin_raw = {device_select_n, rd_strobe_n, write_pulse_n,
                      addr_bit_two, addr_bit_one, addr_bit_zero, host_data_in};
    assign agree = s2_ff ~^ s3_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
            filt_ff <= '1;
        end else begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= (agree & s3_ff) | (~agree & filt_ff);
        end
    end

    logic cs_n_f, rd_n_f, wr_n_f;
    logic [2:0] addr_f;
    logic [7:0] din_f;
    assign cs_n_f = filt_ff[13];
    assign rd_n_f = filt_ff[12];
    assign wr_n_f = filt_ff[11];
    assign addr_f = filt_ff[10:8];
    assign din_f = filt_ff[7:0];

    // Access sequencer; strobe spacing by the host keeps each edge visible
    uhf_acc_t acc_ff, nxt_acc;
    logic rd_evt, wr_evt;
    logic [2:0] wa_ff;
    logic [7:0] wd_ff;

    always_comb begin
        nxt_acc = acc_ff;
        case (acc_ff)
            ACC_IDLE: begin
                if (!cs_n_f && !rd_n_f) begin
                    nxt_acc = ACC_RD;
                end else if (!cs_n_f && !wr_n_f) begin
                    nxt_acc = ACC_WR;
                end
            end
            ACC_RD: begin
                if (rd_n_f) begin
                    nxt_acc = ACC_IDLE;
                end
            end
            ACC_WR: begin
                if (wr_n_f) begin
                    nxt_acc = ACC_IDLE;
                end
            end
            default: nxt_acc = ACC_IDLE;
        endcase
    end

    assign rd_evt = (acc_ff == ACC_IDLE) && (nxt_acc == ACC_RD);
    assign wr_evt = (acc_ff == ACC_WR) && wr_n_f;

    // Write data is held while the strobe is low, since hold after release is short
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_ff <= ACC_IDLE;
            wa_ff <= '0;
            wd_ff <= BYTE_RST;
        end else begin
            acc_ff <= nxt_acc;
            if (nxt_acc == ACC_WR) begin
                wa_ff <= addr_f;
                wd_ff <= din_f;
            end
        end
    end

    // Registers
    logic [3:0] ier_ff;
    logic [7:0] lcr_ff, scr_ff, dll_ff, dlm_ff, rd_data_ff;
    logic [4:0] mcr_ff;
    logic fifo_en_ff, dma_ff, ovr_ff, thre_irq_ff, tx_emp_d_ff;
    logic trig_d_ff, tmo_d_ff, int_ff;
    logic [1:0] trig_ff;
    logic [EVT_W-1:0] evt_sts_ff, evt_msk_ff, evt_set;
    logic [5:0] tmo_cnt_ff;
    logic dlab;
    assign dlab = lcr_ff[LCR_DLAB_BIT];

    logic w_thr, w_ier, w_fcr, w_lcr, w_mcr, w_scr, w_dll, w_dlm, w_est, w_emk;
    assign w_thr = wr_evt && hit(wa_ff, OFS_DATA, dlab, DL_OFF);
    assign w_ier = wr_evt && hit(wa_ff, OFS_IER, dlab, DL_OFF);
    assign w_fcr = wr_evt && hit(wa_ff, OFS_IIR_FCR, dlab, DL_ANY);
    assign w_lcr = wr_evt && hit(wa_ff, OFS_LCR, dlab, DL_ANY);
    assign w_mcr = wr_evt && hit(wa_ff, OFS_MCR, dlab, DL_OFF);
    assign w_scr = wr_evt && hit(wa_ff, OFS_SCR, dlab, DL_ANY);
    assign w_dll = wr_evt && hit(wa_ff, OFS_DATA, dlab, DL_ON);
    assign w_dlm = wr_evt && hit(wa_ff, OFS_IER, dlab, DL_ON);
    assign w_est = wr_evt && hit(wa_ff, OFS_EVT_STS, dlab, DL_ON);
    assign w_emk = wr_evt && hit(wa_ff, OFS_EVT_MSK, dlab, DL_ON);

    logic r_rbr, r_ier, r_iir, r_lcr, r_mcr, r_lsr, r_scr, r_dll, r_dlm, r_est, r_emk;
    assign r_rbr = hit(addr_f, OFS_DATA, dlab, DL_OFF);
    assign r_ier = hit(addr_f, OFS_IER, dlab, DL_OFF);
    assign r_iir = hit(addr_f, OFS_IIR_FCR, dlab, DL_ANY);
    assign r_lcr = hit(addr_f, OFS_LCR, dlab, DL_ANY);
    assign r_mcr = hit(addr_f, OFS_MCR, dlab, DL_OFF);
    assign r_lsr = hit(addr_f, OFS_LSR, dlab, DL_OFF);
    assign r_scr = hit(addr_f, OFS_SCR, dlab, DL_ANY);
    assign r_dll = hit(addr_f, OFS_DATA, dlab, DL_ON);
    assign r_dlm = hit(addr_f, OFS_IER, dlab, DL_ON);
    assign r_est = hit(addr_f, OFS_EVT_STS, dlab, DL_ON);
    assign r_emk = hit(addr_f, OFS_EVT_MSK, dlab, DL_ON);

    // FIFOs
    uhf_fifo_if #(.WIDTH(8), .DEPTH(DEPTH)) rx_f();
    uhf_fifo_if #(.WIDTH(8), .DEPTH(DEPTH)) tx_f();

    uhf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .f(rx_f.store)
    );
    uhf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .f(tx_f.store)
    );

    logic en_change, rx_pop, tx_pop;
    assign en_change = w_fcr && (wd_ff[FCR_EN_BIT] != fifo_en_ff);
    assign rx_pop = rd_evt && r_rbr;
    assign tx_pop = tx_out_valid && tx_out_ready;
    assign rx_f.clear = en_change || (w_fcr && wd_ff[FCR_RXRST_BIT]);
    assign tx_f.clear = en_change || (w_fcr && wd_ff[FCR_TXRST_BIT]);
    assign rx_f.one_deep = !fifo_en_ff;
    assign tx_f.one_deep = !fifo_en_ff;
    assign rx_f.push = rx_in_valid;
    assign rx_f.push_data = rx_in_data;
    assign rx_f.pop = rx_pop;
    assign tx_f.push = w_thr;
    assign tx_f.push_data = wd_ff;
    assign tx_f.pop = tx_pop;
    assign tx_out_valid = !tx_f.empty;
    assign tx_out_data = tx_f.head;

    // Character time in bit ticks, framing taken from the line control
    logic [3:0] char_bits;
    logic [5:0] tmo_lim;
    logic tmo_hit, trig_hit, rx_lvl, tmo_irq, thre_irq;
    logic [CNT_W-1:0] rx_cnt;
    assign rx_cnt = rx_f.count;
    assign char_bits = START_BITS + BASE_WORD_BITS + {2'b00, lcr_ff[1:0]}
        + {3'b000, lcr_ff[LCR_PEN_BIT]}
        + (lcr_ff[LCR_STB_BIT] ? TWO_STOP : ONE_STOP);
    assign tmo_lim = 6'(32'(char_bits) * TIMEOUT_CHARS);
    assign tmo_hit = (tmo_cnt_ff >= tmo_lim) && !rx_f.empty;
    assign trig_hit = fifo_en_ff ? (rx_cnt >= TRIG_LVL[trig_ff]) : !rx_f.empty;
    assign rx_lvl = ier_ff[IER_RX_BIT] && trig_hit;
    assign tmo_irq = ier_ff[IER_RX_BIT] && fifo_en_ff && tmo_hit;
    assign thre_irq = ier_ff[IER_TX_BIT] && thre_irq_ff;

    logic [3:0] iir_id;
    logic [7:0] iir_byte, lsr_byte, rd_mux;
    assign iir_id = rx_lvl ? IIR_RXDATA : tmo_irq ? IIR_TIMEOUT
        : thre_irq ? IIR_THRE : IIR_NONE;
    assign iir_byte = {fifo_en_ff, fifo_en_ff, 2'b00, iir_id};
    assign lsr_byte = {1'b0, tx_f.empty, tx_f.empty, 3'b000, ovr_ff, !rx_f.empty};
    assign rd_mux = r_rbr ? rx_f.head : r_ier ? {4'h0, ier_ff} : r_iir ? iir_byte
        : r_lcr ? lcr_ff : r_mcr ? {3'h0, mcr_ff} : r_lsr ? lsr_byte
        : r_scr ? scr_ff : r_dll ? dll_ff : r_dlm ? dlm_ff
        : r_est ? {5'h0, evt_sts_ff} : r_emk ? {5'h0, evt_msk_ff} : BYTE_RST;

    assign evt_set[EVT_TRIG_BIT] = trig_hit && !trig_d_ff;
    assign evt_set[EVT_TMO_BIT] = tmo_hit && !tmo_d_ff;
    assign evt_set[EVT_OVR_BIT] = rx_in_valid && rx_f.full;

    // Flags set by hardware win over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ier_ff <= '0;
            lcr_ff <= LCR_RST;
            mcr_ff <= '0;
            scr_ff <= BYTE_RST;
            dll_ff <= BYTE_RST;
            dlm_ff <= BYTE_RST;
            fifo_en_ff <= 1'b0;
            dma_ff <= 1'b0;
            trig_ff <= TRIG_RST;
            evt_msk_ff <= '0;
        end else begin
            if (w_ier) ier_ff <= wd_ff[3:0];
            if (w_lcr) lcr_ff <= wd_ff;
            if (w_mcr) mcr_ff <= wd_ff[4:0];
            if (w_scr) scr_ff <= wd_ff;
            if (w_dll) dll_ff <= wd_ff;
            if (w_dlm) dlm_ff <= wd_ff;
            if (w_emk) evt_msk_ff <= wd_ff[EVT_W-1:0];
            if (w_fcr) begin
                fifo_en_ff <= wd_ff[FCR_EN_BIT];
                dma_ff <= wd_ff[FCR_DMA_BIT];
                trig_ff <= wd_ff[FCR_TRIG_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt_sts_ff <= '0;
            ovr_ff <= 1'b0;
            thre_irq_ff <= 1'b0;
            tx_emp_d_ff <= 1'b1;
            trig_d_ff <= 1'b0;
            tmo_d_ff <= 1'b0;
            int_ff <= 1'b0;
            rd_data_ff <= BYTE_RST;
            tmo_cnt_ff <= '0;
        end else begin
            evt_sts_ff <= (evt_sts_ff & ~(w_est ? wd_ff[EVT_W-1:0] : '0)) | evt_set;
            ovr_ff <= evt_set[EVT_OVR_BIT] || (ovr_ff && !(rd_evt && r_lsr));
            thre_irq_ff <= (tx_f.empty && !tx_emp_d_ff)
                || (thre_irq_ff && !w_thr && !(rd_evt && r_iir && iir_id == IIR_THRE));
            tx_emp_d_ff <= tx_f.empty;
            trig_d_ff <= trig_hit;
            tmo_d_ff <= tmo_hit;
            int_ff <= !iir_id[0] || (|(evt_sts_ff & evt_msk_ff));
            if (rd_evt) rd_data_ff <= rd_mux;
            // Arrival or host read restarts the idle measure
            if (rx_f.push || rx_pop || rx_f.empty) begin
                tmo_cnt_ff <= '0;
            end else if (bit_tick && tmo_cnt_ff < tmo_lim) begin
                tmo_cnt_ff <= tmo_cnt_ff + 6'h01;
            end
        end
    end

    assign host_data_out = rd_data_ff;
    assign host_data_oe = (acc_ff == ACC_RD);
    assign host_interrupt_out = int_ff;
    assign dma_mode_active = dma_ff && fifo_en_ff;
    assign line_ctrl = lcr_ff;
    assign baud_divisor = {dlm_ff, dll_ff};

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_fifo_enable: assert property (
        w_fcr && wd_ff[FCR_EN_BIT] |=> fifo_en_ff && !rx_f.one_deep)
        else $error("FIFO enable write not taken");
    a_fifo_depth: assert property (
        rx_cnt <= CNT_W'(DEPTH) && tx_f.count <= CNT_W'(DEPTH))
        else $error("FIFO count beyond depth");
    a_dma_gate: assert property (
        !fifo_en_ff |-> !dma_mode_active)
        else $error("DMA mode active without FIFOs");
    a_single_buffer: assert property (
        !fifo_en_ff && !$past(fifo_en_ff) |-> rx_cnt <= 1 && tx_f.count <= 1)
        else $error("Legacy mode holds more than one byte");
    a_rx_read_order: assert property (
        rx_pop && !rx_f.empty |=> host_data_out == $past(rx_f.head) && host_data_oe)
        else $error("Receive read returned wrong byte");
    a_tx_queue: assert property (
        w_thr && !tx_f.full && !tx_pop && !tx_f.clear |=> tx_f.count == $past(tx_f.count) + 1)
        else $error("Transmit write not queued");
    a_ready_flag: assert property (
        rx_in_valid && rx_f.empty && !rx_f.clear |=> lsr_byte[0] ##0 !rx_f.empty)
        else $error("Data ready flag missed arrival");
    a_trig_code: assert property (
        fifo_en_ff && ier_ff[IER_RX_BIT] && rx_cnt >= TRIG_LVL[trig_ff] |-> iir_id == 4'h4)
        else $error("Trigger level code missing");
    a_irq_on_trig: assert property (
        fifo_en_ff && ier_ff[IER_RX_BIT] && rx_cnt >= TRIG_LVL[trig_ff] |=> host_interrupt_out)
        else $error("Interrupt pin not raised at trigger");
    a_tmo_code: assert property (
        ier_ff[IER_RX_BIT] && fifo_en_ff && !trig_hit && tmo_hit |-> iir_id == 4'hc)
        else $error("Timeout code missing");
    a_two_stop_time: assert property (
        lcr_ff[1:0] == 2'h3 && !lcr_ff[LCR_PEN_BIT] && lcr_ff[LCR_STB_BIT] |-> tmo_lim == 6'd44)
        else $error("Character time ignores second stop bit");
    a_irq_release: assert property (
        iir_id[0] && !(|(evt_sts_ff & evt_msk_ff)) |=> !host_interrupt_out)
        else $error("Interrupt pin stuck high");
    a_read_clears_tmo: assert property (
        rx_pop |=> !tmo_hit [*2])
        else $error("Receive read left timeout pending");

    c_rx_read: cover property (rx_pop ##[1:8] !host_data_oe);
    c_timeout: cover property (iir_id == IIR_TIMEOUT);
    c_rx_full: cover property (fifo_en_ff && rx_f.full);
    c_tx_drain: cover property (tx_pop && tx_f.count == 1);
endmodule // uhf_host_port

// ### testbench/uhf_pump_model.sv
`timescale 1ns/10ps
module uhf_pump_model (
    input wire logic clk,
    input wire logic stall,
    output logic rx_in_valid,
    output logic [7:0] rx_in_data,
    output logic bit_tick,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    output logic tx_out_ready
);
    logic [7:0] got [$];

    initial begin
        rx_in_valid = 1'b0;
        rx_in_data = 8'h00;
        bit_tick = 1'b0;
    end

    // A stalled sink lets the transmit queue fill up behind the buffer
    assign tx_out_ready = ~stall;

    always @(posedge clk) begin
        if (tx_out_valid === 1'b1 && tx_out_ready) begin
            got.push_back(tx_out_data);
        end
    end

    task automatic send(input logic [7:0] d);
        @(posedge clk);
        rx_in_valid <= 1'b1;
        rx_in_data <= d;
        @(posedge clk);
        rx_in_valid <= 1'b0;
        // Data no longer qualified, so it must not keep the old character
        rx_in_data <= ~d;
    endtask

    // Bit times only run while a test asks for them, so idle checks are not racing a timer
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule // uhf_pump_model

// ### testbench/uart_style_host_fifo_port_test.sv
`timescale 1ns/10ps
module uart_style_host_fifo_port_test;
    import uhf_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [2:0] adr = 3'h0;
    logic [7:0] wdat = 8'h00;
    logic stall = 1'b1;
    logic [7:0] hout, rxd, txd, lctl;
    logic [15:0] bdiv;
    logic oe, irq, rxv, tick, txv, txr, dma;
    int n_fail = 0;
    int n_checks = 0;
    int lv [4] = '{1, 4, 8, 14};

    always #20 clk = ~clk;

    uhf_host_port dut (
        .clk(clk), .sys_rst(sys_rst), .device_select_n(cs_n),
        .rd_strobe_n(rd_n), .write_pulse_n(wr_n), .addr_bit_zero(adr[0]),
        .addr_bit_one(adr[1]), .addr_bit_two(adr[2]), .host_data_in(wdat),
        .host_data_out(hout), .host_data_oe(oe), .host_interrupt_out(irq),
        .rx_in_valid(rxv), .rx_in_data(rxd), .bit_tick(tick),
        .tx_out_valid(txv), .tx_out_data(txd), .tx_out_ready(txr),
        .dma_mode_active(dma), .line_ctrl(lctl), .baud_divisor(bdiv)
    );

    uhf_pump_model u_pump (
        .clk(clk), .stall(stall), .rx_in_valid(rxv), .rx_in_data(rxd),
        .bit_tick(tick), .tx_out_valid(txv), .tx_out_data(txd), .tx_out_ready(txr)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobes are held far longer than the pin synchronisers need
    task automatic hwr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        adr <= a;
        wdat <= d;
        wr_n <= 1'b0;
        repeat (5) @(posedge clk);
        wr_n <= 1'b1;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic hrd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        adr <= a;
        rd_n <= 1'b0;
        repeat (20) if (oe !== 1'b1) @(negedge clk);
        if (oe !== 1'b1) begin
            n_fail++;
            close_out;
        end
        d = hout;
        @(posedge clk);
        rd_n <= 1'b1;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        hrd(a, d);
        check(what, d, exp);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(negedge clk);
        check("irq", {7'h00, irq}, {7'h00, e});
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        close_out;
    end

    initial begin
        int k;
        int j;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        irq_is(1'b0);
        check("txv", {7'h00, txv}, 8'h00);
        // Legacy mode holds one character and refuses the next
        u_pump.send(8'ha5);
        u_pump.send(8'h5a);
        rchk("lsr", OFS_LSR, 8'h63);
        rchk("rbr", OFS_DATA, 8'ha5);
        rchk("lsr", OFS_LSR, 8'h60);
        hwr(OFS_IIR_FCR, 8'h08);
        check("dma", {7'h00, dma}, 8'h00);
        hwr(OFS_IIR_FCR, 8'h09);
        check("dma", {7'h00, dma}, 8'h01);
        rchk("iir", OFS_IIR_FCR, 8'hc1);
        // Fill the transmit queue past its depth while the sink stalls
        for (k = 0; k < 17; k++) hwr(OFS_DATA, 8'h30 + k[7:0]);
        check("txv", {7'h00, txv}, 8'h01);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        check("txn", 8'(u_pump.got.size()), 8'h10);
        for (k = 0; k < 16; k++) check("txd", u_pump.got[k], 8'h30 + k[7:0]);
        hwr(OFS_IER, 8'h01);
        for (k = 0; k < 4; k++) begin
            hwr(OFS_IIR_FCR, {k[1:0], 6'h03});
            for (j = 1; j < lv[k]; j++) u_pump.send(8'h40 + j[7:0]);
            irq_is(1'b0);
            u_pump.send(8'h40 + lv[k][7:0]);
            irq_is(1'b1);
            rchk("iir", OFS_IIR_FCR, 8'hc4);
            rchk("rbr", OFS_DATA, 8'h41);
            irq_is(1'b0);
            for (j = 2; j <= lv[k]; j++) rchk("rbr", OFS_DATA, 8'h40 + j[7:0]);
            rchk("lsr", OFS_LSR, 8'h60);
        end
        // Character time 7 bits with one stop bit, 11 with eight data bits and two
        for (k = 0; k < 2; k++) begin
            hwr(OFS_LCR, (k == 1) ? 8'h07 : 8'h00);
            hwr(OFS_IIR_FCR, 8'hc3);
            u_pump.send(8'h77);
            u_pump.ticks((k == 1) ? 42 : 26);
            rchk("iir", OFS_IIR_FCR, 8'hc1);
            u_pump.ticks(4);
            rchk("iir", OFS_IIR_FCR, 8'hcc);
            irq_is(1'b1);
            rchk("rbr", OFS_DATA, 8'h77);
            rchk("iir", OFS_IIR_FCR, 8'hc1);
        end
        hwr(OFS_MCR, 8'hff);
        rchk("mcr", OFS_MCR, 8'h1f);
        hwr(OFS_LCR, 8'h80);
        check("lcr", lctl, 8'h80);
        rchk("evt", OFS_EVT_STS, 8'h07);
        irq_is(1'b0);
        hwr(OFS_EVT_MSK, 8'h07);
        irq_is(1'b1);
        hwr(OFS_EVT_STS, 8'h07);
        rchk("evt", OFS_EVT_STS, 8'h00);
        irq_is(1'b0);
        rchk("msk", OFS_EVT_MSK, 8'h07);
        hwr(OFS_DATA, 8'h12);
        hwr(OFS_IER, 8'h34);
        check("dll", bdiv[7:0], 8'h12);
        check("dlm", bdiv[15:8], 8'h34);
        rchk("dll", OFS_DATA, 8'h12);
        hwr(OFS_SCR, 8'h5c);
        rchk("scr", OFS_SCR, 8'h5c);
        rchk("gap", 3'h6, 8'h00);
        close_out;
    end
endmodule // uart_style_host_fifo_port_test
